// file: src/asw_host.sv
`timescale 1ns/100ps
module asw_host
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input asw_pkg::asw_req_t req_in,
    output logic rd_valid_out,
    output logic [asw_pkg::DATA_W-1:0] rd_data_out,
    output asw_pkg::asw_pins_t pins_out,
    input wire logic [asw_pkg::DATA_W-1:0] shared_data_lines_in,
    output logic [asw_pkg::DATA_W-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe_out
);
    import asw_pkg::*;

    ////////////////////////////////////////////////////////////////
    asw_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    asw_req_t req_r, req_nxt;
    asw_pins_t pins_r, pins_nxt;
    logic oe_r, oe_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
    logic [DATA_W-1:0] capt;
    logic [1:0] lane_on;
    logic take;
    logic cnt_done;
    logic rd_done;
    logic wr_done;

    ////////////////////////////////////////////////////////////////
    // disabled lanes float, so they are returned as zero
    assign lane_on = {req_r.high_lane, req_r.low_lane};

    for (genvar g = 0; g < 2; g++)
    begin : g_lane
        assign capt[8*g +: 8] = lane_on[g] ? shared_data_lines_in[8*g +: 8] : 8'h00;
    end

    // a request is only taken in idle, so a busy cycle never half-takes one
    assign take = req_valid_in && (state_r == ST_IDLE);
    assign cnt_done = (cnt_r == CNT_ZERO);
    assign rd_done = (state_r == ST_READ) && cnt_done;
    assign wr_done = (state_r == ST_WRITE) && cnt_done;

    ////////////////////////////////////////////////////////////////
    // sequencer: state and wait counter
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (take && req_in.write)
                begin
                    cnt_nxt = STORE_CNT;
                    state_nxt = ST_WRITE;
                end
                else if (take)
                begin
                    cnt_nxt = ACCESS_CNT;
                    state_nxt = ST_READ;
                end
            end
            ST_READ:
            begin
                if (cnt_done)
                begin
                    cnt_nxt = RELEASE_CNT;
                    state_nxt = ST_RD_REL;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_RD_REL:
            begin
                // wait out the release before the bus can be driven
                if (cnt_done)
                begin
                    state_nxt = ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_WRITE:
            begin
                if (cnt_done)
                begin
                    state_nxt = ST_WR_END;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_WR_END:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin driver: request copy, strobes and bus drive
    always_comb
    begin
        req_nxt = req_r;
        pins_nxt = pins_r;
        oe_nxt = oe_r;
        if (take)
        begin
            req_nxt = req_in;
            // index, select and lanes set together; one index per cycle
            pins_nxt.word_index = req_in.word_index;
            pins_nxt.select_n = 1'b0;
            pins_nxt.low_lane_enable_n = ~req_in.low_lane;
            pins_nxt.high_lane_enable_n = ~req_in.high_lane;
            if (req_in.write)
            begin
                // drive stays off, memory never drives during the write
                pins_nxt.drive_n = 1'b1;
                pins_nxt.store_n = 1'b0;
                oe_nxt = 1'b1;
            end
            else
            begin
                pins_nxt.store_n = 1'b1;
                pins_nxt.drive_n = 1'b0;
                oe_nxt = 1'b0;
            end
        end
        else if (rd_done)
        begin
            // drive and select rise together, the bus floats before the index moves
            pins_nxt.drive_n = 1'b1;
            pins_nxt.select_n = 1'b1;
        end
        else if (wr_done)
        begin
            // strobe rises first; index, data held one more cycle
            pins_nxt.store_n = 1'b1;
        end
        else if (state_r == ST_WR_END)
        begin
            pins_nxt.select_n = 1'b1;
            pins_nxt.low_lane_enable_n = 1'b1;
            pins_nxt.high_lane_enable_n = 1'b1;
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            req_r <= '0;
            pins_r <= '{word_index: '0, default: 1'b1};
            oe_r <= 1'b0;
        end
        else
        begin
            req_r <= req_nxt;
            pins_r <= pins_nxt;
            oe_r <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read result: one-cycle valid, data held until the next read
    always_comb
    begin
        rd_valid_nxt = 1'b0;
        rd_data_nxt = rd_data_r;
        if (rd_done)
        begin
            // sampled before the index moves, old data still held
            rd_data_nxt = capt;
            rd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 16'h0000;
        end
        else
        begin
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // ready is combinational so a waiting request is taken on the first idle edge
    assign req_ready_out = (state_r == ST_IDLE);
    assign rd_valid_out = rd_valid_r;
    assign rd_data_out = rd_data_r;
    assign pins_out = pins_r;
    assign shared_data_lines_out = req_r.data;
    assign shared_data_lines_oe_out = oe_r;
endmodule : asw_host

// file: src/asw_pkg.sv
// How it works
// - low lane lines 1-8, high lane 9-16
// - read: store high, select and drive low
// - host never fights memory while it drives
// - store pulse 10 ns with drive off
// - store pulse 15 ns with drive on
// - index valid 10 ns before write end
// - select low 10 ns before write end
// - lanes valid 10 ns before write end
// - write data valid 7 ns before end
// - each read spans one stable index
package asw_pkg;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned ACCESS_MAX_PS = 15000;
    localparam int unsigned DRIVE_ACCESS_MAX_PS = 7000;
    localparam int unsigned RELEASE_MAX_PS = 7000;
    localparam int unsigned STORE_PULSE_MIN_PS = 15000;
    localparam int unsigned DATA_SETUP_MIN_PS = 7000;
    localparam int unsigned LANE_SETUP_MIN_PS = 10000;
    // most and least times both round up, so cycle counts cover the slowest grade
    localparam int unsigned ACCESS_CYC = (ACCESS_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RELEASE_CYC = (RELEASE_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STORE_CYC_RAW = (STORE_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETUP_CYC = (LANE_SETUP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STORE_CYC = (STORE_CYC_RAW > SETUP_CYC) ? STORE_CYC_RAW : SETUP_CYC;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC + 1);
    localparam logic [CNT_W-1:0] RELEASE_CNT = CNT_W'(RELEASE_CYC);
    localparam logic [CNT_W-1:0] STORE_CNT = CNT_W'(STORE_CYC);
    localparam int unsigned IDX_W = 18;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef struct packed {
        logic write;
        logic [IDX_W-1:0] word_index;
        logic [DATA_W-1:0] data;
        logic low_lane;
        logic high_lane;
    } asw_req_t;

    typedef struct packed {
        logic [IDX_W-1:0] word_index;
        logic select_n;
        logic store_n;
        logic drive_n;
        logic low_lane_enable_n;
        logic high_lane_enable_n;
    } asw_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_RD_REL = 3'b010,
        ST_WRITE = 3'b011,
        ST_WR_END = 3'b100
    } asw_state_t;
endpackage : asw_pkg

// file: tb/asw_host_checker.sv
`timescale 1ns/100ps
module asw_host_checker
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire asw_pkg::asw_req_t req_in,
    input wire logic rd_valid_out,
    input wire asw_pkg::asw_pins_t pins_out,
    input wire logic shared_data_lines_oe_out
);
    import asw_pkg::*;
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);
    wire logic st = pins_out.store_n;
    wire logic drv = pins_out.drive_n;
    sequence s_rd; req_valid_in && req_ready_out && !req_in.write; endsequence
    sequence s_wr; req_valid_in && req_ready_out && req_in.write; endsequence
    property p_no_fight; shared_data_lines_oe_out |-> drv; endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives in read");
    property p_read_mode; !drv |-> st && !pins_out.select_n; endproperty
    a_read_mode: assert property (p_read_mode) else $error("bad read mode");
    property p_pulse; $fell(st) |-> !st [*2]; endproperty
    a_pulse: assert property (p_pulse) else $error("store pulse short");
    property p_data_setup; $rose(st) |-> $past(shared_data_lines_oe_out); endproperty
    a_data_setup: assert property (p_data_setup) else $error("no write data");
    property p_index_hold; !st && !$past(st) |-> $stable(pins_out.word_index); endproperty
    a_index_hold: assert property (p_index_hold) else $error("index moved in write");
    property p_sel_write; !st |-> !pins_out.select_n; endproperty
    a_sel_write: assert property (p_sel_write) else $error("store without select");
    property p_read_index; !drv && !$past(drv) |-> $stable(pins_out.word_index); endproperty
    a_read_index: assert property (p_read_index) else $error("index moved in read");
    property p_store_no_drive; !st |-> drv; endproperty
    a_store_no_drive: assert property (p_store_no_drive) else $error("drive on during store");
    property p_answer; s_rd |-> ##5 rd_valid_out; endproperty
    a_answer: assert property (p_answer) else $error("read answer late");
    property p_lane_map; s_wr |=> pins_out.low_lane_enable_n != $past(req_in.low_lane)
        && pins_out.high_lane_enable_n != $past(req_in.high_lane); endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane enables wrong");
endmodule : asw_host_checker
bind asw_host asw_host_checker i_chk (.sys_clk_in, .rstn_in, .req_valid_in, .req_ready_out, .req_in,
    .rd_valid_out, .pins_out, .shared_data_lines_oe_out);

// file: tb/asw_host_tb_top.sv
`timescale 1ns/100ps
module asw_host_tb_top;
    import asw_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic req_valid_in = 1'b0;
    asw_req_t req_in = '0;
    logic req_ready_out, rd_valid_out, oe;
    logic [DATA_W-1:0] rd_data_out, host_q, mem_q, bus;
    asw_pins_t pins_out;
    int failures = 0;
    int samples_checked = 0;
    assign bus = oe ? host_q : mem_q;
    asw_host i_dut (.sys_clk_in, .rstn_in, .req_valid_in, .req_ready_out, .req_in, .rd_valid_out,
        .rd_data_out, .pins_out, .shared_data_lines_in(bus), .shared_data_lines_out(host_q),
        .shared_data_lines_oe_out(oe));
    asw_sram_model i_mem (.pins_in(pins_out), .data_in(bus), .data_out(mem_q));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // ln[0] low lane, ln[1] high lane
    task automatic send(input logic wr, input logic [IDX_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] ln);
        @(posedge sys_clk_in);
        req_valid_in <= 1'b1;
        req_in <= {wr, a, d, ln[0], ln[1]};
        @(negedge sys_clk_in);
        for (int i = 0; i < 20 && req_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
        if (req_ready_out !== 1'b1)
        begin
            failures++;
            $display("ERROR %0t request never taken", $time);
        end
        @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
    endtask : send
    task automatic rd_chk(input logic [IDX_W-1:0] a, input logic [1:0] ln, input logic [DATA_W-1:0] exp);
        send(1'b0, a, 16'h0000, ln);
        for (int i = 0; i < 20 && rd_valid_out !== 1'b1; i++) @(negedge sys_clk_in);
        chk({15'h0000, rd_valid_out}, 16'h0001);
        chk(rd_data_out, exp);
    endtask : rd_chk
    task automatic t_reset;
        chk({10'h000, oe, pins_out[4:0]}, 16'h001F);
    endtask : t_reset
    // extreme indexes back to back
    task automatic t_full;
        send(1'b1, 18'h3_FFFF, 16'h1234, 2'b11);
        send(1'b1, 18'h0_0000, 16'hABCD, 2'b11);
        rd_chk(18'h3_FFFF, 2'b11, 16'h1234);
        rd_chk(18'h0_0000, 2'b11, 16'hABCD);
    endtask : t_full
    task automatic t_lanes;
        send(1'b1, 18'h0_0005, 16'hFFFF, 2'b11);
        send(1'b1, 18'h0_0005, 16'h00AA, 2'b01);
        send(1'b1, 18'h0_0005, 16'h5500, 2'b10);
        send(1'b1, 18'h0_0005, 16'h0000, 2'b00);
        rd_chk(18'h0_0005, 2'b11, 16'h55AA);
        rd_chk(18'h0_0005, 2'b10, 16'h5500);
        rd_chk(18'h0_0005, 2'b01, 16'h00AA);
    endtask : t_lanes
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_full();
        t_lanes();
        stop_test();
    end
    // about ten transfers of under ten cycles each; twenty-five times that
    initial
    begin
        #20000;
        failures++;
        stop_test();
    end
endmodule : asw_host_tb_top

// file: tb/asw_sram_model.sv
`timescale 1ns/100ps
module asw_sram_model
#(
    parameter int ACCESS_NS = 15,
    parameter int HOLD_NS = 3
)
(
    input wire asw_pkg::asw_pins_t pins_in,
    input wire logic [asw_pkg::DATA_W-1:0] data_in,
    output logic [asw_pkg::DATA_W-1:0] data_out
);
    import asw_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];
    logic [DATA_W-1:0] junk = 16'hA5C3;
    wire logic sel = pins_in.select_n;
    wire logic st = pins_in.store_n;
    wire logic lo = pins_in.low_lane_enable_n;
    wire logic hi = pins_in.high_lane_enable_n;
    wire logic [DATA_W-1:0] lm = {{8{!hi}}, {8{!lo}}};
    wire logic rd = !sel && !pins_in.drive_n && st;
    wire logic rd_late;
    wire logic [IDX_W-1:0] idx_held;
    assign #(ACCESS_NS) rd_late = rd;
    // the old word stays on the lanes a moment after the index moves
    assign #(HOLD_NS) idx_held = pins_in.word_index;
    // released lanes move every 4 ns so a stale sample cannot pass
    always #4 junk = ~junk;
    assign data_out = (rd && rd_late) ? (mem[idx_held] & lm) | (junk & ~lm) : junk;
    // stores at the end of the overlap, only if the other strobe is still low
    always @(posedge st or posedge sel)
    begin
        if ((st ^ sel) && !lo) mem[pins_in.word_index][7:0] = data_in[7:0];
        if ((st ^ sel) && !hi) mem[pins_in.word_index][15:8] = data_in[15:8];
    end
endmodule : asw_sram_model
